//--- bench/test_ttc_trace.sv
// Purpose: self-checking bench for the trace trigger and capture block
// Assumes: APB master tasks, CPU cycles from the bus model
// Notes:   trace words are read back through the index register
`timescale 1ns/1ps
`include "ttc_cfg.svh"
module test_ttc_trace;
  localparam logic [31:0] EN   = 32'h00000001;
  localparam logic [31:0] ARM  = 32'h00000002;
  localparam logic [31:0] ENDM = 32'h00000004;
  localparam logic [4:0]  PF   = 5'h10;
  localparam logic [4:0]  FR   = 5'h08;
  localparam logic [4:0]  SRC  = 5'h04;
  localparam logic [4:0]  DST  = 5'h02;
  localparam logic [4:0]  VEC  = 5'h01;
  localparam logic [4:0]  PL   = 5'h00;
  // Per trigger code: miss address, hit address, flags set by the hit
  localparam logic [3:0][3:0]  TCODE = {4'h8, 4'h7, 4'h1, 4'h0};
  localparam logic [3:0][15:0] TMISS = {16'h0150, 16'h0300, 16'h0150, 16'h0150};
  localparam logic [3:0][15:0] THIT  = {16'h0300, 16'h0150, 16'h0200, 16'h0100};
  localparam logic [3:0][3:0]  TFLAG = {4'h0, 4'h0, 4'h2, 4'h1};

  logic              pclk;
  logic              presetn;
  logic              psel;
  logic              penable;
  logic              pwrite;
  logic [11:0]       paddr;
  logic [31:0]       pwdata;
  logic [31:0]       prdata;
  logic              pready;
  logic              pslverr;
  ttc_pkg::ttc_bus_t cpu_bus;
  logic              trace_armed;
  logic              cmp_c_break;
  logic [31:0]       rdata;
  logic              rerr;
  int                error_cnt;
  int                tests_run;
  int                brk_cnt;
  int                n;

  ttc_trace ttc_trace_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .cpu_bus, .trace_armed, .cmp_c_break);
  ttc_cpu_model ttc_cpu_model_i (.pclk, .cpu_bus);

  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    if (cmp_c_break === 1'b1) brk_cnt <= brk_cnt + 1;
  end

  task automatic end_sim;
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : end_sim

  task automatic chk32(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk32

  task automatic chk1(input string what, input logic exp, input logic got);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %b seen %b", what, exp, got);
    end
  endtask : chk1

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rdata = prdata;
    rerr  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rd(input string what, input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h00000000);
    chk32(what, exp, rdata);
  endtask : rd

  // Index register feeds the store a cycle late, so one idle edge first
  task automatic entry(input logic [31:0] idx, input logic [31:0] exp);
    wr(`TTC_OFF_RDIDX, idx);
    @(posedge pclk);
    rd("trace word", `TTC_OFF_DATA, exp);
  endtask : entry

  task automatic arm(input logic [3:0] trigger_select_field, input logic [31:0] ctrl);
    wr(`TTC_OFF_STATUS, {24'h0, trigger_select_field, 4'h0});
    wr(`TTC_OFF_CTRL, ctrl);
  endtask : arm

  task automatic cpu(input logic [15:0] a, input logic [15:0] d, input logic [4:0] k);
    ttc_cpu_model_i.cyc(a, d, k);
  endtask : cpu

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    error_cnt = 0;
    tests_run = 0;
    brk_cnt = 0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rd("ctrl reset", `TTC_OFF_CTRL, 32'h00000000);
    rd("count reset", `TTC_OFF_COUNT, 32'h00000000);
    apb(1'b0, 12'h020, 32'h00000000);
    chk32("unmapped read", `TTC_ERR_DATA, rdata);
    chk1("unmapped error", 1'b1, rerr);
    wr(`TTC_OFF_CTRL, ARM);
    rd("arm without enable", `TTC_OFF_CTRL, 32'h00000000);
    for (int k = 0; k < 9; k++) begin
      wr(`TTC_OFF_STATUS, {24'h0, 4'(k), 4'h7});
      rd("trigger select", `TTC_OFF_STATUS, {24'h0, 4'(k), 4'h0});
    end
    for (int c = 0; c < 4; c++) begin
      wr(`TTC_OFF_CTRL, {27'h0, 2'(c), 3'h1});
      rd("capture select", `TTC_OFF_CTRL, {27'h0, 2'(c), 3'h1});
    end
    $display("test registers done");
    wr(`TTC_OFF_CMPA, 32'h00000100);
    wr(`TTC_OFF_CMPB, 32'h00000200);
    for (int i = 0; i < 4; i++) begin
      arm(TCODE[i], EN | ARM | ENDM);
      cpu(TMISS[i], 16'h0000, PL);
      rd("before hit", `TTC_OFF_STATUS, {24'h0, TCODE[i], 4'h0});
      cpu(THIT[i], 16'h0000, PL);
      rd("after hit", `TTC_OFF_STATUS, {22'h0, 2'b01, TCODE[i], TFLAG[i]});
      rd("arm after hit", `TTC_OFF_CTRL, EN | ENDM);
      chk1("armed pin", 1'b0, trace_armed);
    end
    arm(4'h2, EN | ARM | ENDM);
    cpu(16'h0200, 16'h0000, PL);
    apb(1'b0, `TTC_OFF_STATUS, 32'h00000000);
    chk1("b before a", 1'b0, rdata[8]);
    cpu(16'h0100, 16'h0000, PL);
    cpu(16'h0200, 16'h0000, PL);
    apb(1'b0, `TTC_OFF_STATUS, 32'h00000000);
    chk32("a then b", 32'h00000123, {23'h0, rdata[8:0]});
    $display("test trigger modes done");
    arm(4'h0, EN | ARM | ENDM);
    for (int i = 0; i < 70; i++) cpu(16'h1000 + 16'(i), 16'h0000, SRC);
    cpu(16'h0100, 16'h0000, PL);
    rd("end count", `TTC_OFF_COUNT, 32'h00000040);
    entry(32'h00000000, 32'h00001006);
    entry(32'h0000003F, 32'h00001045);
    arm(4'h1, EN | ARM);
    cpu(16'h0700, 16'h0000, SRC);
    cpu(16'h0200, 16'h0000, SRC);
    for (int i = 0; i < 70; i++) cpu(16'h2000 + 16'(i), 16'h0000, SRC);
    rd("begin count", `TTC_OFF_COUNT, 32'h00000040);
    rd("arm on full", `TTC_OFF_CTRL, EN);
    rd("full status", `TTC_OFF_STATUS, 32'h00000312);
    entry(32'h00000000, 32'h00000200);
    entry(32'h0000003F, 32'h0000203E);
    $display("test begin and end done");
    arm(4'h3, EN | ARM);
    cpu(16'h0300, 16'h1111, SRC);
    cpu(16'h0200, 16'h5A5A, PL);
    cpu(16'h0310, 16'h2222, SRC);
    rd("event count", `TTC_OFF_COUNT, 32'h00000001);
    entry(32'h00000000, 32'h00005A5A);
    arm(4'h0, EN | ARM | 32'h00000010);
    cpu(16'h0100, 16'h1111, PL);
    cpu(16'h0400, 16'h2222, PF);
    cpu(16'h0402, 16'h2323, FR);
    cpu(16'h0500, 16'h3333, PL);
    rd("detail count", `TTC_OFF_COUNT, 32'h00000002);
    entry(32'h00000000, 32'h01001111);
    entry(32'h00000001, 32'h05003333);
    $display("test event and detail done");
    wr(`TTC_OFF_CMPC, 32'h00001234);
    arm(4'h0, EN | ARM);
    n = brk_cnt;
    cpu(16'h1234, 16'h0000, PL);
    repeat (2) @(posedge pclk);
    chk1("c break normal", 1'b1, brk_cnt != n);
    arm(4'h0, EN | ARM | ENDM | 32'h00000008);
    rd("c after loop arm", `TTC_OFF_CMPC, 32'h00000000);
    n = brk_cnt;
    cpu(16'h0700, 16'h0000, SRC);
    cpu(16'h0700, 16'h0000, SRC);
    rd("c after store", `TTC_OFF_CMPC, 32'h00010700);
    cpu(16'h0700, 16'h0000, PL);
    cpu(16'h0800, 16'h0000, DST);
    cpu(16'h0800, 16'h0000, DST);
    cpu(16'hFFFE, 16'h0000, VEC);
    cpu(16'hFFFE, 16'h0000, VEC);
    rd("loop count", `TTC_OFF_COUNT, 32'h00000005);
    repeat (2) @(posedge pclk);
    chk1("c break loop", 1'b0, brk_cnt != n);
    chk1("armed pin", 1'b1, trace_armed);
    $display("test loop1 done");
    end_sim();
  end

  // Whole run needs well under a thousand cycles
  initial begin
    repeat (20000) @(posedge pclk);
    error_cnt++;
    $display("[ERR] watchdog expected finish seen hang");
    end_sim();
  end
endmodule : test_ttc_trace

//--- bench/ttc_cpu_model.sv
// Purpose: CPU bus model that feeds observed cycles to the trace block
// Assumes: one bus cycle per call, then one idle cycle
// Notes:   idle cycles show the inverse of the last address and data, kind bits zero
`timescale 1ns/1ps
module ttc_cpu_model (
  // Clock
  input  wire logic         pclk,
  // Observed bus
  output ttc_pkg::ttc_bus_t cpu_bus
);
  initial begin
    cpu_bus = 38'h0;
  end

  // Kind bits: prog fetch, free, cof source, cof destination, vector
  task automatic cyc(input logic [15:0] a, input logic [15:0] d, input logic [4:0] kind);
    @(posedge pclk);
    cpu_bus <= {1'b1, a, d, kind};
    @(posedge pclk);
    // Stale address must not look like a second match
    cpu_bus <= {1'b0, ~a, ~d, 5'h00};
  endtask : cyc
endmodule : ttc_cpu_model

//--- rtl/ttc_cfg.svh
// Purpose: constants for the trace trigger and capture block
// Assumes: APB with 32-bit data, word-aligned registers
// Notes:   trigger mode codes are a local encoding
`ifndef TTC_CFG_SVH
`define TTC_CFG_SVH
`define TTC_DEPTH        64
`define TTC_OFF_CTRL     12'h000
`define TTC_OFF_STATUS   12'h004
`define TTC_OFF_CMPA     12'h008
`define TTC_OFF_CMPB     12'h00C
`define TTC_OFF_CMPC     12'h010
`define TTC_OFF_DATA     12'h014
`define TTC_OFF_COUNT    12'h018
`define TTC_OFF_RDIDX    12'h01C
`define TTC_CTRL_EN      0
`define TTC_CTRL_ARM     1
`define TTC_CTRL_END     2
`define TTC_CTRL_CAP_LO  3
`define TTC_CTRL_CAP_HI  4
`define TTC_ST_A         0
`define TTC_ST_B         1
`define TTC_ST_C         2
`define TTC_ST_TRG_LO    4
`define TTC_ST_TRG_HI    7
`define TTC_ST_TRIGD     8
`define TTC_ST_FULL      9
`define TTC_CMPC_IGN     16
`define TTC_ERR_DATA     32'hDEADBEEF
`define TTC_ZERO32       32'h00000000
`endif

//--- rtl/ttc_pkg.sv
// Purpose: shared types of the trace trigger and capture block
// Assumes: nothing beyond the constants header
// Notes:   trigger select uses nine local codes
package ttc_pkg;
  typedef enum logic [3:0] {
    TTC_TRG_A_ONLY   = 4'h0,
    TTC_TRG_A_OR_B   = 4'h1,
    TTC_TRG_A_THEN_B = 4'h2,
    TTC_TRG_EV_B     = 4'h3,
    TTC_TRG_A_THEN_EV_B = 4'h4,
    TTC_TRG_A_AND_B  = 4'h5,
    TTC_TRG_A_NOT_B  = 4'h6,
    TTC_TRG_IN_RANGE = 4'h7,
    TTC_TRG_OUT_RANGE = 4'h8
  } ttc_trg_t;
  typedef enum logic [1:0] {
    TTC_CAP_NORMAL = 2'h0,
    TTC_CAP_LOOP1  = 2'h1,
    TTC_CAP_DETAIL = 2'h2,
    TTC_CAP_PROFILE = 2'h3
  } ttc_cap_t;
  // One observed CPU bus cycle
  typedef struct packed {
    logic        valid;
    logic [15:0] addr;
    logic [15:0] data;
    logic        prog_fetch;
    logic        free_cyc;
    logic        cof_src;
    logic        cof_dst;
    logic        vector;
  } ttc_bus_t;
endpackage : ttc_pkg

//--- rtl/ttc_trace.sv
// Purpose: trace trigger and capture logic with APB registers
// Assumes: CPU bus cycles arrive as one struct per pclk
// Notes:   trace data readable through an index register
// Functional notes
// - Begin-trigger: store after trigger until 64 entries are held.
// - End-trigger: store until trigger, oldest entry dropped beyond 64.
// - Arm clears on trigger in end mode, on full in begin mode.
// - Nine selectable trigger modes qualify start or end of storage.
// - Comparator A match sets flag A; B match sets flag B except in A-only mode and before A in sequence modes.
// - Arming clears the A, B and C flags.
// - Change-of-flow addresses stored except event-only and detail modes.
// - Event-only modes store the data bus value at event B.
// - Detail stores address and data except program fetch and free cycles.
// - A-only: A match sets flag A and triggers.
// - A-or-B: either match sets its flag and triggers.
// - A-then-B: B checked only after A; trigger when B follows.
// - Four capture modes are selectable.
// - Normal: A and B trigger; trigger select picks stored content.
// - Loop1: stored address loads comparator C in ignore-address mode.
// - Arming in loop1 clears comparator C.
// - Loop1 disables comparator C breakpoints.
// - Loop1 suppresses only repeated source addresses.
// - Loop1 compares CPU address only, paging ignored.
//
// The APB interface to the registers and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "ttc_cfg.svh"
module ttc_trace #(
  parameter int DEPTH = `TTC_DEPTH,
  parameter int AW    = $clog2(DEPTH)
) (
  // Clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  // APB slave
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [11:0]      paddr,
  input  wire logic [31:0]      pwdata,
  output logic      [31:0]      prdata,
  output logic                  pready,
  output logic                  pslverr,
  // Observed CPU bus
  input  wire ttc_pkg::ttc_bus_t cpu_bus,
  // Debug outputs
  output logic                  trace_armed,
  output logic                  cmp_c_break
);
  logic            en;
  logic            arm;
  logic            end_mode;
  ttc_pkg::ttc_cap_t cap;
  ttc_pkg::ttc_trg_t trigger_select_field;
  logic            flag_a;
  logic            flag_b;
  logic            flag_c;
  logic            trigd;
  logic            a_seen;
  logic [15:0]     cmp_a;
  logic [15:0]     cmp_b;
  logic [15:0]     cmp_c;
  logic            cmp_c_ign;
  logic [AW-1:0]   rd_idx;
  logic [31:0]     buf_rd;
  logic [AW:0]     buf_cnt;

  wire logic acc    = psel && penable;
  wire logic wr_acc = acc && pwrite;
  wire logic arm_wr = wr_acc && paddr == `TTC_OFF_CTRL &&
                      pwdata[`TTC_CTRL_EN] && pwdata[`TTC_CTRL_ARM];
  wire logic active = en && arm;
  wire logic loop1  = cap == ttc_pkg::TTC_CAP_LOOP1;
  wire logic detail = cap == ttc_pkg::TTC_CAP_DETAIL;
  wire logic ev_only = trigger_select_field == ttc_pkg::TTC_TRG_EV_B ||
                       trigger_select_field == ttc_pkg::TTC_TRG_A_THEN_EV_B;
  wire logic buf_full = buf_cnt == (AW+1)'(DEPTH);

  // Comparator matches on valid bus cycles
  wire logic v     = cpu_bus.valid && active;
  wire logic hit_a = v && cpu_bus.addr == cmp_a;
  wire logic hit_b = v && cpu_bus.addr == cmp_b;
  // Loop1 ignores paging: plain CPU address compare
  wire logic hit_c = v && cpu_bus.addr == cmp_c;

  // Trigger decision per mode
  logic next_trig;
  logic b_armed;
  always_comb begin
    b_armed = a_seen || hit_a;
    case (trigger_select_field)
      ttc_pkg::TTC_TRG_A_ONLY:      next_trig = hit_a;
      ttc_pkg::TTC_TRG_A_OR_B:      next_trig = hit_a || hit_b;
      ttc_pkg::TTC_TRG_A_THEN_B:    next_trig = a_seen && hit_b;
      ttc_pkg::TTC_TRG_EV_B:        next_trig = hit_b;
      ttc_pkg::TTC_TRG_A_THEN_EV_B: next_trig = a_seen && hit_b;
      ttc_pkg::TTC_TRG_A_AND_B:     next_trig = hit_a && hit_b;
      ttc_pkg::TTC_TRG_A_NOT_B:     next_trig = hit_a && !hit_b;
      ttc_pkg::TTC_TRG_IN_RANGE:    next_trig = v && cpu_bus.addr >= cmp_a &&
                                                cpu_bus.addr <= cmp_b;
      ttc_pkg::TTC_TRG_OUT_RANGE:   next_trig = v && (cpu_bus.addr < cmp_a ||
                                                cpu_bus.addr > cmp_b);
      default:                      next_trig = 1'b0;
    endcase
  end
  wire logic trig_now = next_trig && !trigd;

  // Event B for event-only modes
  wire logic ev_b = ev_only && hit_b &&
                    (trigger_select_field == ttc_pkg::TTC_TRG_EV_B || a_seen);

  // Storage window: begin mode after trigger, end mode until it
  wire logic window = end_mode ? !trigd : (trigd || trig_now);

  // What to store this cycle
  logic        store;
  logic [31:0] store_data;
  always_comb begin
    store      = 1'b0;
    store_data = `TTC_ZERO32;
    if (v && window) begin
      if (detail) begin
        store      = !cpu_bus.prog_fetch && !cpu_bus.free_cyc;
        store_data = {cpu_bus.addr, cpu_bus.data};
      end else if (ev_only) begin
        store      = ev_b;
        store_data = {16'h0000, cpu_bus.data};
      end else begin
        // Source repeats dropped in loop1; destinations and vectors kept
        store = (cpu_bus.cof_src && !(loop1 && cmp_c_ign && hit_c)) ||
                cpu_bus.cof_dst || cpu_bus.vector;
        store_data = {16'h0000, cpu_bus.addr};
      end
    end
  end
  wire logic wr_en = store && !(!end_mode && buf_full);

  ttc_trace_buf #(
    .DEPTH (DEPTH),
    .AW    (AW)
  ) u_buf (
    .pclk    (pclk),
    .presetn (presetn),
    .clear   (arm_wr),
    .wr_en   (wr_en),
    .wr_data (store_data),
    .rd_idx  (rd_idx),
    .rd_data (buf_rd),
    .count   (buf_cnt)
  );

  // Control register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en       <= 1'b0;
      arm      <= 1'b0;
      end_mode <= 1'b0;
      cap      <= ttc_pkg::TTC_CAP_NORMAL;
    end else begin
      if (wr_acc && paddr == `TTC_OFF_CTRL) begin
        en       <= pwdata[`TTC_CTRL_EN];
        arm      <= pwdata[`TTC_CTRL_EN] && pwdata[`TTC_CTRL_ARM];
        end_mode <= pwdata[`TTC_CTRL_END];
        cap      <= ttc_pkg::ttc_cap_t'(pwdata[`TTC_CTRL_CAP_HI:`TTC_CTRL_CAP_LO]);
      end else if (active && ((end_mode && trig_now) ||
                              (!end_mode && buf_full))) begin
        arm <= 1'b0;
      end
    end
  end

  // Trigger select, flags, sequence state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trigger_select_field    <= ttc_pkg::TTC_TRG_A_ONLY;
      flag_a <= 1'b0;
      flag_b <= 1'b0;
      flag_c <= 1'b0;
      trigd  <= 1'b0;
      a_seen <= 1'b0;
    end else if (arm_wr) begin
      flag_a <= 1'b0;
      flag_b <= 1'b0;
      flag_c <= 1'b0;
      trigd  <= 1'b0;
      a_seen <= 1'b0;
    end else begin
      if (wr_acc && paddr == `TTC_OFF_STATUS)
        trigger_select_field <= ttc_pkg::ttc_trg_t'(pwdata[`TTC_ST_TRG_HI:`TTC_ST_TRG_LO]);
      if (hit_a)
        flag_a <= 1'b1;
      // B only compared once A has been seen in sequence modes
      if (hit_b && (trigger_select_field == ttc_pkg::TTC_TRG_A_ONLY ? 1'b0 :
                    (trigger_select_field == ttc_pkg::TTC_TRG_A_THEN_B ||
                     trigger_select_field == ttc_pkg::TTC_TRG_A_THEN_EV_B) ? a_seen : 1'b1))
        flag_b <= 1'b1;
      if (hit_c && !loop1)
        flag_c <= 1'b1;
      if (b_armed && active)
        a_seen <= 1'b1;
      if (trig_now && active)
        trigd <= 1'b1;
    end
  end

  // Comparators; C reloads from stored addresses in loop1
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmp_a     <= '0;
      cmp_b     <= '0;
      cmp_c     <= '0;
      cmp_c_ign <= 1'b0;
    end else if (arm_wr && pwdata[`TTC_CTRL_CAP_HI:`TTC_CTRL_CAP_LO] ==
                 ttc_pkg::TTC_CAP_LOOP1) begin
      cmp_c     <= '0;
      cmp_c_ign <= 1'b0;
    end else begin
      if (wr_acc && paddr == `TTC_OFF_CMPA)
        cmp_a <= pwdata[15:0];
      if (wr_acc && paddr == `TTC_OFF_CMPB)
        cmp_b <= pwdata[15:0];
      if (loop1 && wr_en && !ev_only && !detail) begin
        cmp_c     <= store_data[15:0];
        cmp_c_ign <= 1'b1;
      end else if (wr_acc && paddr == `TTC_OFF_CMPC) begin
        cmp_c     <= pwdata[15:0];
        cmp_c_ign <= pwdata[`TTC_CMPC_IGN];
      end
    end
  end

  // C breakpoint is suppressed while loop1 owns comparator C
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      cmp_c_break <= 1'b0;
    else
      cmp_c_break <= hit_c && !loop1;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      rd_idx <= '0;
    else if (wr_acc && paddr == `TTC_OFF_RDIDX)
      rd_idx <= pwdata[AW-1:0];
  end

  assign trace_armed = arm;

  // APB: zero wait, error on unmapped addresses
  wire logic mapped = paddr == `TTC_OFF_CTRL || paddr == `TTC_OFF_STATUS ||
                      paddr == `TTC_OFF_CMPA || paddr == `TTC_OFF_CMPB ||
                      paddr == `TTC_OFF_CMPC || paddr == `TTC_OFF_DATA ||
                      paddr == `TTC_OFF_COUNT || paddr == `TTC_OFF_RDIDX;
  assign pready  = 1'b1;
  assign pslverr = acc && !mapped;

  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = `TTC_ZERO32;
    case (paddr)
      `TTC_OFF_CTRL:   rd_mux = {27'h0, cap, end_mode, arm, en};
      `TTC_OFF_STATUS: rd_mux = {22'h0, buf_full, trigd, trigger_select_field, 1'b0,
                                 flag_c, flag_b, flag_a};
      `TTC_OFF_CMPA:   rd_mux = {16'h0000, cmp_a};
      `TTC_OFF_CMPB:   rd_mux = {16'h0000, cmp_b};
      `TTC_OFF_CMPC:   rd_mux = {15'h0000, cmp_c_ign, cmp_c};
      `TTC_OFF_DATA:   rd_mux = buf_rd;
      `TTC_OFF_COUNT:  rd_mux = {{(31-AW){1'b0}}, buf_cnt};
      `TTC_OFF_RDIDX:  rd_mux = {{(32-AW){1'b0}}, rd_idx};
      default:         rd_mux = `TTC_ERR_DATA;
    endcase
  end
  // Read data comes from a flop; valid at setup-to-access edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      prdata <= '0;
    else if (psel && !penable)
      prdata <= rd_mux;
  end

  property p_arm_clears_flags;
    @(posedge pclk) disable iff (!presetn)
      arm_wr |=> !flag_a && !flag_b && !flag_c;
  endproperty
  a_arm_clears_flags: assert property (p_arm_clears_flags)
    else $error("flags not cleared by arming");

  property p_end_trig_disarms;
    @(posedge pclk) disable iff (!presetn)
      active && end_mode && trig_now && !arm_wr |=> !arm;
  endproperty
  a_end_trig_disarms: assert property (p_end_trig_disarms)
    else $error("arm kept after end trigger");

  property p_begin_full_stop;
    @(posedge pclk) disable iff (!presetn)
      !end_mode && buf_full && !arm_wr |=> $stable(buf_cnt);
  endproperty
  a_begin_full_stop: assert property (p_begin_full_stop)
    else $error("storage after buffer full");

  property p_begin_wait;
    @(posedge pclk) disable iff (!presetn)
      !end_mode && !trigd && !trig_now |-> !wr_en;
  endproperty
  a_begin_wait: assert property (p_begin_wait)
    else $error("stored before begin trigger");

  property p_flag_a;
    @(posedge pclk) disable iff (!presetn)
      hit_a && !arm_wr |=> flag_a;
  endproperty
  a_flag_a: assert property (p_flag_a)
    else $error("flag A not set");

  property p_a_then_b;
    @(posedge pclk) disable iff (!presetn)
      trigger_select_field == ttc_pkg::TTC_TRG_A_THEN_B && trig_now |-> a_seen;
  endproperty
  a_a_then_b: assert property (p_a_then_b)
    else $error("B triggered before A");

  property p_detail_skip;
    @(posedge pclk) disable iff (!presetn)
      detail && (cpu_bus.prog_fetch || cpu_bus.free_cyc) |-> !wr_en;
  endproperty
  a_detail_skip: assert property (p_detail_skip)
    else $error("fetch or free cycle stored");

  property p_loop1_c_load;
    @(posedge pclk) disable iff (!presetn)
      loop1 && wr_en && !ev_only && !detail && !arm_wr |=>
        cmp_c == $past(store_data[15:0]) && cmp_c_ign;
  endproperty
  a_loop1_c_load: assert property (p_loop1_c_load)
    else $error("comparator C not loaded");

  property p_c_break_off;
    @(posedge pclk) disable iff (!presetn)
      loop1 |=> !cmp_c_break;
  endproperty
  a_c_break_off: assert property (p_c_break_off)
    else $error("C breakpoint in loop1");
endmodule : ttc_trace

//--- rtl/ttc_trace_buf.sv
// Purpose: 64-entry circular trace store
// Assumes: one write per cycle at most
// Notes:   oldest entry falls out on overflow
`timescale 1ns/1ps
`include "ttc_cfg.svh"
module ttc_trace_buf #(
  parameter int DEPTH = `TTC_DEPTH,
  parameter int AW    = $clog2(DEPTH)
) (
  // Clock and reset
  input  wire logic          pclk,
  input  wire logic          presetn,
  // Control
  input  wire logic          clear,
  input  wire logic          wr_en,
  input  wire logic [31:0]   wr_data,
  // Read side, index 0 is oldest
  input  wire logic [AW-1:0] rd_idx,
  output logic      [31:0]   rd_data,
  output logic      [AW:0]   count
);
  logic [31:0]   mem [DEPTH];
  logic [AW-1:0] wptr;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wptr  <= '0;
      count <= '0;
    end else if (clear) begin
      wptr  <= '0;
      count <= '0;
    end else if (wr_en) begin
      wptr <= wptr + 1'b1;
      if (count != (AW+1)'(DEPTH))
        count <= count + 1'b1;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < DEPTH; gi++) begin : g_ent
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
          mem[gi] <= '0;
        else if (wr_en && !clear && wptr == AW'(gi))
          mem[gi] <= wr_data;
      end
    end
  endgenerate

  // Oldest entry sits at wptr once full
  logic [AW-1:0] base;
  always_comb begin
    base = (count == (AW+1)'(DEPTH)) ? wptr : '0;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      rd_data <= '0;
    else
      rd_data <= mem[AW'(base + rd_idx)];
  end
endmodule : ttc_trace_buf
